// ### include/ssbs_pkg.sv
// package: constants and types of the synchronous serial byte shifter
package ssbs_pkg;

  localparam int unsigned BYTE_BITS         = 8;     // bits per transfer
  localparam int unsigned SYS_CLK_PERIOD_PS = 8000;  // sys_clk period, ps
  localparam int unsigned SCK_CYCLE_MIN_PS  = 62500; // least serial cycle, ps
  // half serial period in sys_clk cycles, rounded up (least time)
  localparam int unsigned HALF_DIV_CYC =
    (SCK_CYCLE_MIN_PS + 2 * SYS_CLK_PERIOD_PS - 1) / (2 * SYS_CLK_PERIOD_PS);
  localparam logic [3:0] BIT_CNT_RST = 4'h0;    // bit counter after reset
  localparam logic [7:0] DATA_RST    = 8'h00;   // shift data after reset
  localparam logic       SDO_RST     = 1'b0;    // data pin after reset

  // one-hot transfer states
  typedef enum logic [1:0] {
    SSBS_IDLE = 2'b01,
    SSBS_RUN  = 2'b10
  } ssbs_state_t;

  // configuration set by software
  typedef struct packed {
    logic master;   // 1: this end makes the serial clock
    logic pol_neg;  // 1: negative polarity, clock rests low
  } ssbs_cfg_t;

  // pin outputs toward the peer
  typedef struct packed {
    logic sck_o;    // serial clock out
    logic sck_oe;   // serial clock driven
    logic sdo;      // serial data out
  } ssbs_pins_t;

endpackage

// ### core/ssbs_core.sv
// module: eight-bit synchronous serial shifter, master or slave
`timescale 1ns/1ps
`default_nettype none

module ssbs_core #(
  parameter int unsigned HALF_DIV = ssbs_pkg::HALF_DIV_CYC
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // software configuration
  input  wire ssbs_pkg::ssbs_cfg_t cfg,
  // user data side
  input  wire logic               start,
  input  wire logic [7:0]         tx_data,
  output var  logic [7:0]         rx_data,
  output var  logic               done,
  output var  logic               busy,
  // serial pins
  input  wire logic               sck_i,
  input  wire logic               sdi,
  output var  ssbs_pkg::ssbs_pins_t pins
);
  import ssbs_pkg::*;

  localparam int unsigned DW = $clog2(HALF_DIV + 1); // divider width
  localparam logic [DW-1:0] DIV_LAST = DW'(HALF_DIV - 1);
  localparam logic [3:0]    BIT_LAST = 4'(BYTE_BITS - 1);

  // synchronisers for the pins
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg; // s3 keeps last synced level
  logic sdi_s1_reg, sdi_s2_reg;

  // transfer state
  ssbs_state_t state_reg, state_next;
  ssbs_cfg_t   cfg_reg, cfg_next;          // config held during a byte
  logic [DW-1:0] div_reg, div_next;        // half period divider
  logic [3:0]  bit_reg, bit_next;          // sampled bit count
  logic [7:0]  tx_reg, tx_next;            // outgoing shift data
  logic [7:0]  rx_reg, rx_next;            // incoming shift data
  logic [7:0]  rxo_reg, rxo_next;          // last received byte
  logic        sck_reg, sck_next;          // driven serial clock
  logic        oe_reg, oe_next;            // clock output enable
  logic        sdo_reg, sdo_next;          // data pin
  logic        done_reg, done_next;        // byte complete pulse
  logic        busy_reg, busy_next;        // transfer in progress

  // edge events
  logic tick;       // master half period elapsed
  logic s_rise;     // synced peer clock rose
  logic s_fall;     // synced peer clock fell
  logic lead_ev;    // shift-out edge
  logic trail_ev;   // sample edge

  // pin synchronisers, two flops before any use
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sdi_s1_reg <= sdi;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  // edge detection on the synced clock and the own divider
  always_comb begin
    // divider ticks only when this end owns the serial clock
    tick   = (state_reg == SSBS_RUN) && cfg_reg.master
             && (div_reg == DIV_LAST);
    s_rise = sck_s2_reg && !sck_s3_reg;
    s_fall = !sck_s2_reg && sck_s3_reg;
    if (cfg_reg.master) begin
      // master: first tick leaves the rest level, second returns
      lead_ev  = tick && (sck_reg == !cfg_reg.pol_neg);
      trail_ev = tick && (sck_reg == cfg_reg.pol_neg);
    end else if (cfg_reg.pol_neg) begin
      // slave, negative polarity
      lead_ev  = (state_reg == SSBS_RUN) && s_rise;
      trail_ev = (state_reg == SSBS_RUN) && s_fall;
    end else begin
      // slave, positive polarity
      lead_ev  = (state_reg == SSBS_RUN) && s_fall;
      trail_ev = (state_reg == SSBS_RUN) && s_rise;
    end
  end

  // next state of the transfer
  always_comb begin
    state_next = state_reg;
    cfg_next   = cfg_reg;
    div_next   = div_reg;
    bit_next   = bit_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    rxo_next   = rxo_reg;
    sck_next   = sck_reg;
    oe_next    = oe_reg;
    sdo_next   = sdo_reg;
    done_next  = 1'b0;
    busy_next  = busy_reg;
    case (state_reg)
      SSBS_IDLE: begin
        // clock rests at the polarity's level
        cfg_next = cfg;
        sck_next = !cfg.pol_neg;
        oe_next  = cfg.master;
        if (start) begin
          // take the byte, keep the last bit on the pin
          state_next = SSBS_RUN;
          div_next   = '0;
          bit_next   = BIT_CNT_RST;
          tx_next    = tx_data;
          busy_next  = 1'b1;
        end
      end
      SSBS_RUN: begin
        // divider counts in both roles; only the master ticks
        if (tick) begin
          div_next = '0;
          sck_next = !sck_reg;
        end else begin
          div_next = DW'(div_reg + 1'b1);
        end
        // shift out on the lead edge, msb first
        if (lead_ev) begin
          sdo_next = tx_reg[7];
          tx_next  = {tx_reg[6:0], 1'b0};
        end
        // sample on the trail edge
        if (trail_ev) begin
          rx_next  = {rx_reg[6:0], sdi_s2_reg};
          bit_next = 4'(bit_reg + 1'b1);
          if (bit_reg == BIT_LAST) begin
            // eighth sample: clock is back at rest, sdo kept
            state_next = SSBS_IDLE;
            rxo_next   = {rx_reg[6:0], sdi_s2_reg};
            done_next  = 1'b1;
            busy_next  = 1'b0;
          end
        end
      end
      default: begin
        // illegal code: back to rest
        state_next = SSBS_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // transfer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= SSBS_IDLE;
      cfg_reg   <= '0;
      div_reg   <= '0;
      bit_reg   <= BIT_CNT_RST;
      tx_reg    <= DATA_RST;
      rx_reg    <= DATA_RST;
      rxo_reg   <= DATA_RST;
      sck_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      sdo_reg   <= SDO_RST;
      done_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      tx_reg    <= tx_next;
      rx_reg    <= rx_next;
      rxo_reg   <= rxo_next;
      sck_reg   <= sck_next;
      oe_reg    <= oe_next;
      sdo_reg   <= sdo_next;
      done_reg  <= done_next;
      busy_reg  <= busy_next;
    end
  end

  // outputs straight from flops
  assign rx_data     = rxo_reg;
  assign done        = done_reg;
  assign busy        = busy_reg;
  assign pins.sck_o  = sck_reg;
  assign pins.sck_oe = oe_reg;
  assign pins.sdo    = sdo_reg;

  // checks
  // done is seen 16 * HALF_DIV + 1 edges after the start edge (master)
  localparam int XFER_WAIT = 16 * HALF_DIV - 1; // edges after start + 2
  logic m_pos, m_neg;                           // master polarity helpers
  assign m_pos = cfg_reg.master && !cfg_reg.pol_neg && busy_reg;
  assign m_neg = cfg_reg.master && cfg_reg.pol_neg && busy_reg;

  property p_role_oe;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == SSBS_RUN) |-> (oe_reg == cfg_reg.master);
  endproperty
  a_role_oe: assert property (p_role_oe) else $error("clock enable vs role");

  property p_pol_rest;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == SSBS_IDLE) ##1 (state_reg == SSBS_IDLE)
        |-> (sck_reg == !$past(cfg.pol_neg));
  endproperty
  a_pol_rest: assert property (p_pol_rest) else $error("rest level vs polarity");

  property p_pos_shift;
    @(posedge sys_clk) disable iff (reset)
      (m_pos && $changed(sdo_reg)) |-> $fell(sck_reg);
  endproperty
  a_pos_shift: assert property (p_pos_shift) else $error("pos data not on fall");

  property p_pos_end;
    @(posedge sys_clk) disable iff (reset)
      (done_reg && !cfg_reg.pol_neg && cfg_reg.master)
        |-> sck_reg ##1 ($stable(sdo_reg) && sck_reg);
  endproperty
  a_pos_end: assert property (p_pos_end) else $error("pos end not high/held");

  property p_neg_shift;
    @(posedge sys_clk) disable iff (reset)
      (m_neg && $changed(sdo_reg)) |-> $rose(sck_reg);
  endproperty
  a_neg_shift: assert property (p_neg_shift) else $error("neg data not on rise");

  property p_neg_end;
    @(posedge sys_clk) disable iff (reset)
      (done_reg && cfg_reg.pol_neg && cfg_reg.master)
        |-> !sck_reg ##1 ($stable(sdo_reg) && !sck_reg);
  endproperty
  a_neg_end: assert property (p_neg_end) else $error("neg end not low/held");

  property p_byte_len;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == SSBS_IDLE && start && cfg.master)
        |=> !done_reg [*2] ##XFER_WAIT done_reg;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("master byte length");

  property p_done_pulse;
    @(posedge sys_clk) disable iff (reset)
      done_reg |-> !busy_reg ##1 !done_reg;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

  c_master_pos: cover property (@(posedge sys_clk) done_reg && m_pos == 1'b0
    && cfg_reg.master && !cfg_reg.pol_neg);
  c_master_neg: cover property (@(posedge sys_clk) done_reg
    && cfg_reg.master && cfg_reg.pol_neg);
  c_slave_byte: cover property (@(posedge sys_clk) done_reg && !cfg_reg.master);

endmodule
`default_nettype wire

// ### test/ssbs_peer.sv
// behavioural serial peer for the byte shifter bench
`timescale 1ns/1ps
`default_nettype none
module ssbs_peer (
  // setup from the bench
  input  wire logic       pol_neg,
  input  wire logic       drv_clk,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte,
  // serial lines
  input  wire logic       sck_dut,
  input  wire logic       sdo,
  output var  logic       sck_pk,
  output var  logic       sdi
);
  logic       run = 1'b0;      // peer clock inside a frame
  logic       in_frame = 1'b0; // peer owns the clock now
  logic [7:0] sh = 8'h00;      // bits still to send
  logic       sck_line;        // clock that both ends see
  // clock stands at rest outside frames
  assign sck_pk   = in_frame ? run : !pol_neg;
  assign sck_line = drv_clk ? sck_pk : sck_dut;
  initial begin
    sdi = 1'b0;
    rx_byte = 8'h00;
  end
  // lead edge shifts out, the other edge samples
  always @(sck_line) begin
    if (sck_line === pol_neg) begin
      sdi = sh[7];
      sh = {sh[6:0], 1'b0};
    end else begin
      rx_byte = {rx_byte[6:0], sdo};
    end
  end
  // load a byte; as clock owner run eight periods of 80 ns
  always @(posedge go) begin
    sh = tx_byte;
    rx_byte = 8'h00;
    if (drv_clk) begin
      run = !pol_neg;
      in_frame = 1'b1;
      repeat (8) begin
        #40 run = pol_neg;
        #40 run = !pol_neg;
      end
      in_frame = 1'b0;
      #40 sdi = !sdi; // line released: stale value not kept
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the serial byte shifter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssbs_pkg::*;
  // half serial period; below 3 the two-flop data synchroniser misses bits
  localparam int unsigned HD = HALF_DIV_CYC;
  logic       sys_clk, reset, start, done, busy, go, sck_pk, sdi;
  logic [7:0] tx_data, rx_data, ptx, prx;
  ssbs_cfg_t  cfg;
  ssbs_pins_t pins;
  int         bad_count = 0, tests_run = 0, cycles = 0;
  ssbs_core #(.HALF_DIV(HD)) i_ssbs_core (.sys_clk(sys_clk), .reset(reset),
    .cfg(cfg), .start(start), .tx_data(tx_data), .rx_data(rx_data),
    .done(done), .busy(busy), .sck_i(sck_pk), .sdi(sdi), .pins(pins));
  ssbs_peer i_ssbs_peer (.pol_neg(cfg.pol_neg), .drv_clk(!cfg.master),
    .go(go), .tx_byte(ptx), .rx_byte(prx), .sck_dut(pins.sck_o),
    .sdo(pins.sdo), .sck_pk(sck_pk), .sdi(sdi));
  // clock generator
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // compare one value and report a mismatch at once
  task automatic check(input logic [7:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // count edges until done, bounded
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (done !== 1'b1 && n < 200);
  endtask
  // two back-to-back master bytes, a refused start in each
  task automatic run_master(input logic neg, input logic [7:0] a, b);
    int n;
    repeat (2) @(posedge sys_clk); // let the rest level of a done settle
    #1 cfg = '{master: 1'b1, pol_neg: neg};
    repeat (3) @(posedge sys_clk);
    #1 check(8'(pins.sck_o), 8'(!neg), "rest");
    for (int k = 0; k < 2; k++) begin
      start = 1'b1;
      tx_data = a;
      ptx = b;
      go = 1'b1;
      @(posedge sys_clk);
      #1 start = 1'b0;
      go = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 start = 1'b1;
      tx_data = 8'h5A;
      @(posedge sys_clk);
      #1 start = 1'b0;
      check(8'(pins.sck_oe), 8'h01, "clock driven");
      wait_done(n);
      check(8'(n), 8'(16 * HD - 6), "done delay");
      check(rx_data, b, "rx");
      check(prx, a, "peer rx");
      check(8'(pins.sdo), 8'(a[0]), "held bit");
      check(8'(pins.sck_o), 8'(!neg), "stop level");
      a = ~a;
      b = ~b;
    end
  endtask
  // one slave byte clocked by the peer
  task automatic run_slave(input logic neg, input logic [7:0] a, b);
    int n;
    repeat (2) @(posedge sys_clk); // let the rest level of a done settle
    #1 cfg = '{master: 1'b0, pol_neg: neg};
    tx_data = a;
    ptx = b;
    repeat (4) @(posedge sys_clk);
    #1 start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    go = 1'b1;
    wait_done(n);
    go = 1'b0;
    check(8'(n >= 82 && n <= 86), 8'h01, "slave done");
    check(rx_data, b, "slave rx");
    check(prx, a, "peer rx");
    check({pins.sdo, pins.sck_oe, busy}, {a[0], 2'b00}, "end");
  endtask
  initial begin
    reset = 1'b1;
    start = 1'b0;
    go = 1'b0;
    cfg = '{master: 1'b0, pol_neg: 1'b0};
    tx_data = 8'h00;
    ptx = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'b0;
    check({pins, done, busy}, 8'h10, "reset pins");
    check(rx_data, 8'h00, "reset rx");
    run_master(1'b0, 8'hA5, 8'h3C);
    run_master(1'b1, 8'h96, 8'hC3);
    run_slave(1'b0, 8'h81, 8'h7E);
    run_slave(1'b1, 8'h4B, 8'hD2);
    give_verdict();
  end
endmodule
`default_nettype wire
